/* File: logic/bsu_branch_sequencer_unit.sv */
// Branch decision, link and shadow register control for the sequencer.
`timescale 1ns/10ps
`default_nettype none
module bsu_branch_sequencer_unit (
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   input  wire bsu_pkg::bsu_branch_type branch,
   input  wire logic [14:0]             ext_cond,
   input  wire logic                    fm_read_pending,
   input  wire bsu_pkg::bsu_fmret_type  fm_return,
   input  wire logic                    link_wr_en,
   input  wire logic [11:0]             link_wr_data,
   input  wire logic                    shadow_wr_en,
   input  wire logic [15:0]             shadow_wr_data,
   output logic                         stall,
   output logic                         slot_cancel,
   output logic                         redirect,
   output logic [11:0]                  redirect_addr,
   output bsu_pkg::bsu_cnt_type         cnt_pulse,
   output logic [11:0]                  link_register,
   output logic [15:0]                  fast_memory_shadow_reg
);

   typedef enum logic [1:0] {
      BSU_IDLE,
      BSU_SLOT
   } bsu_state_type;

   bsu_state_type state_q;
   logic          cond_met;
   logic          uncond;
   logic          taken;
   logic          hold;
   logic [11:0]   target;
   logic [11:0]   target_q;
   logic          taken_q;

   assign uncond = (branch.cond_sel == bsu_pkg::SEL_UNCOND);
   assign cond_met = uncond ? 1'b1 :
                     (ext_cond[branch.cond_sel] == branch.polarity);
   // A shadow branch waits on the outstanding read; in the return cycle it still takes the shadow value from before the load.
   assign hold  = branch.valid && (branch.src == bsu_pkg::BSU_SRC_SHADOW)
                  && fm_read_pending && !fm_return.valid;
   assign taken = branch.valid && !hold && cond_met;

   always_comb begin
      case (branch.src)
         bsu_pkg::BSU_SRC_SHADOW: target = fast_memory_shadow_reg[11:0];
         bsu_pkg::BSU_SRC_LINK:   target = link_register;
         default:                 target = branch.imm_target;
      endcase
   end

   // The slot is always fetched; only its effects are cancelled here.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q     <= BSU_IDLE;
         taken_q     <= 1'b0;
         target_q    <= bsu_pkg::PC_RESET;
         slot_cancel <= 1'b0;
      end else if (branch.valid && !hold) begin
         state_q  <= BSU_SLOT;
         taken_q  <= taken;
         target_q <= target;
         // The C bit doubles as nullify when unconditional.
         slot_cancel <= branch.cond_opt && (uncond || !cond_met);
      end else begin
         state_q     <= BSU_IDLE;
         taken_q     <= 1'b0;
         slot_cancel <= 1'b0;
      end
   end

   // Redirect follows the slot cycle; not taken means sequential flow.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         redirect      <= 1'b0;
         redirect_addr <= bsu_pkg::PC_RESET;
      end else begin
         case (state_q)
            BSU_SLOT: begin
               redirect      <= taken_q;
               redirect_addr <= target_q;
            end
            BSU_IDLE: redirect <= 1'b0;
            default:  redirect <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stall <= 1'b0;
      end else begin
         stall <= hold;
      end
   end

   // Counter pulse is independent of the branch outcome.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_pulse <= '0;
      end else begin
         cnt_pulse <= '0;
         if (branch.valid && !hold) begin
            cnt_pulse.dec_receive_occupied  <= (branch.cnt_op == bsu_pkg::CNT_DEC_RX_OCC);
            cnt_pulse.dec_receive_filled    <= (branch.cnt_op == bsu_pkg::CNT_DEC_RX_FIL);
            cnt_pulse.inc_transmit_occupied <= (branch.cnt_op == bsu_pkg::CNT_INC_TX_OCC);
            cnt_pulse.inc_transmit_filled   <= (branch.cnt_op == bsu_pkg::CNT_INC_TX_FIL);
         end
      end
   end

   // Link writes land one cycle later, so software must leave a gap before use.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         link_register <= bsu_pkg::LINK_RESET;
      end else if (taken && branch.linked) begin
         link_register <= 12'(branch.addr + bsu_pkg::LINK_STEP);
      end else if (link_wr_en) begin
         link_register <= link_wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fast_memory_shadow_reg <= bsu_pkg::SHADOW_RESET;
      end else if (fm_return.valid && fm_return.link_opt
                   && (fm_return.halfword != 16'h0000)) begin
         fast_memory_shadow_reg <= fm_return.halfword;
      end else if (shadow_wr_en) begin
         fast_memory_shadow_reg <= shadow_wr_data;
      end
   end

endmodule // bsu_branch_sequencer_unit
`default_nettype wire

/* File: logic/bsu_pkg.sv */
// Package of constants and types for the branch sequencer unit.
//
// Functional notes
// - Unconditional, no nullify: run slot, then target.
// - Condition holds: run slot, then fetch target.
// - Condition fails, no C: run slot, continue sequentially.
// - Condition fails, C present: suppress slot, sequential.
// - Linked variants save address after the slot.
// - Link written only when taken, value address plus two.
// - Register branch with nullify returns via link.
// - Counter operation happens whether or not taken.
// - E0, E1 decrement receive; C2, C3 increment transmit.
// - Shadow branch targets the shadow register value.
// - Shadow branch stalls while fast read pending.
// - Shadow loads only with link option, nonzero halfword.
// - Shadow register is software readable and writable.
// - Condition select 1111 means unconditional branch.
// - Polarity bit picks the tested condition level.
// - Target is low twelve bits, absolute address.
// - Shadow takes first halfword of linked fast read.
package bsu_pkg;

   localparam int         ADDR_W        = 12;
   localparam int         HALF_W        = 16;
   localparam int         COND_W        = 15;
   localparam logic [3:0] SEL_UNCOND    = 4'hF;
   localparam logic [7:0] CNT_DEC_RX_OCC = 8'hE0;
   localparam logic [7:0] CNT_DEC_RX_FIL = 8'hE1;
   localparam logic [7:0] CNT_INC_TX_OCC = 8'hC2;
   localparam logic [7:0] CNT_INC_TX_FIL = 8'hC3;
   localparam logic [11:0] PC_RESET      = 12'h000;
   localparam logic [11:0] LINK_RESET    = 12'h000;
   localparam logic [15:0] SHADOW_RESET  = 16'h0000;
   localparam logic [11:0] LINK_STEP     = 12'h002;
   localparam logic [11:0] SEQ_STEP      = 12'h001;

   typedef enum logic [1:0] {
      BSU_SRC_IMM,
      BSU_SRC_SHADOW,
      BSU_SRC_LINK
   } bsu_src_type;

   // One decoded branch as issued by the instruction decoder.
   typedef struct packed {
      logic        valid;
      bsu_src_type src;
      logic        linked;
      logic [3:0]  cond_sel;
      logic        polarity;
      logic        cond_opt;
      logic [7:0]  cnt_op;
      logic [11:0] imm_target;
      logic [11:0] addr;
   } bsu_branch_type;

   // Fast memory read return carrying the first halfword.
   typedef struct packed {
      logic        valid;
      logic        link_opt;
      logic [15:0] halfword;
   } bsu_fmret_type;

   // Pulses to the four cell-port flow counters.
   typedef struct packed {
      logic dec_receive_occupied;
      logic dec_receive_filled;
      logic inc_transmit_occupied;
      logic inc_transmit_filled;
   } bsu_cnt_type;

endpackage

/* File: tb/bsu_sequencer_assertions.sv */
// Port checker for the branch sequencer unit.
`timescale 1ns/10ps
`default_nettype none
module bsu_sequencer_assertions (
   input wire logic                    clk,
   input wire logic                    reset_n,
   input wire bsu_pkg::bsu_branch_type branch,
   input wire logic [14:0]             ext_cond,
   input wire logic                    fm_read_pending,
   input wire bsu_pkg::bsu_fmret_type  fm_return,
   input wire logic                    stall,
   input wire logic                    slot_cancel,
   input wire logic                    redirect,
   input wire bsu_pkg::bsu_cnt_type    cnt_pulse,
   input wire logic [11:0]             link_register,
   input wire logic [15:0]             fast_memory_shadow_reg
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire hold = branch.src == bsu_pkg::BSU_SRC_SHADOW && fm_read_pending && !fm_return.valid;
   wire tk   = branch.valid && !hold;
   wire unc  = branch.cond_sel == bsu_pkg::SEL_UNCOND;
   wire hit  = unc || ext_cond[branch.cond_sel] == branch.polarity;
   wire ld   = fm_return.valid && fm_return.link_opt && |fm_return.halfword;
   stall_block_a: assert property (branch.valid && hold |=> stall) else $error("no stall");
   cancel_fail_a: assert property (tk && !hit && branch.cond_opt |=> slot_cancel) else $error("slot");
   keep_slot_a: assert property (tk && !branch.cond_opt |=> !slot_cancel) else $error("slot");
   taken_slot_a: assert property (tk && hit && !unc |=> !slot_cancel) else $error("slot");
   redirect_take_a: assert property (tk && hit |=> ##1 redirect) else $error("no jump");
   no_redirect_a: assert property (tk && !hit |=> ##1 !redirect) else $error("jump");
   link_value_a: assert property (tk && hit && branch.linked
      |=> link_register == $past(branch.addr) + 12'h002) else $error("link");
   shadow_load_a: assert property (ld |=> fast_memory_shadow_reg == $past(fm_return.halfword))
      else $error("shadow");
   count_pulse_a: assert property (tk && branch.cnt_op == bsu_pkg::CNT_INC_TX_FIL
      |=> cnt_pulse.inc_transmit_filled) else $error("counter");
   cover property (tk && hit && branch.linked);
   cover property (stall);
   cover property (slot_cancel ##1 redirect);
endmodule // bsu_sequencer_assertions
bind bsu_branch_sequencer_unit bsu_sequencer_assertions u_bsu_sequencer_assertions (.*);
`default_nettype wire

/* File: tb/bsu_branch_sequencer_unit_tb.sv */
// Self-checking bench for the branch sequencer unit.
`timescale 1ns/10ps
`default_nettype none
module bsu_branch_sequencer_unit_tb;
   logic                    clk = 1'b0;
   logic                    reset_n = 1'b0;
   bsu_pkg::bsu_branch_type branch = '0;
   logic                    pend = 1'b0;
   bsu_pkg::bsu_fmret_type  fmr = '0;
   logic                    sw_en = 1'b0;
   logic                    lw_en = 1'b0;
   logic [14:0]             cond = 15'h0002;
   logic                    stall, slot_cancel, redirect;
   logic [11:0]             redirect_addr, link_register;
   bsu_pkg::bsu_cnt_type    cnt_pulse;
   logic [15:0]             shadow;
   int                      bad_count = 0;
   int                      num_checks = 0;
   bsu_branch_sequencer_unit u_bsu_branch_sequencer_unit (.clk(clk), .reset_n(reset_n),
      .branch(branch), .ext_cond(cond), .fm_read_pending(pend), .fm_return(fmr),
      .link_wr_en(lw_en), .link_wr_data(12'h0A5), .shadow_wr_en(sw_en),
      .shadow_wr_data(16'h0ABC), .stall(stall), .slot_cancel(slot_cancel),
      .redirect(redirect), .redirect_addr(redirect_addr), .cnt_pulse(cnt_pulse),
      .link_register(link_register), .fast_memory_shadow_reg(shadow));
   initial forever #5 clk = ~clk;
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   function automatic bsu_pkg::bsu_branch_type mk(logic [1:0] s, logic l, logic [3:0] e,
      logic p, logic o, logic [7:0] n);
      mk = '{1'b1, bsu_pkg::bsu_src_type'(s), l, e, p, o, n, 12'h045, 12'h011};
   endfunction
   // Drives one branch and checks its answer at the cycles the unit promises.
   task automatic go(input bsu_pkg::bsu_branch_type x, input logic c, input logic r,
      input logic [11:0] a, input logic [3:0] n);
      branch = x;
      @(negedge clk);
      branch.valid = 1'b0;
      chk(slot_cancel, c);
      chk(cnt_pulse, n);
      @(negedge clk);
      chk(redirect, r);
      if (r) chk(redirect_addr, a);
      $display("test done at %0t", $time);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   logic [7:0] ops [4] = '{8'hE0, 8'hE1, 8'hC2, 8'hC3};
   initial begin
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      go(mk(0, 0, 4'hF, 0, 0, 0), 0, 1, 12'h045, 0);
      go(mk(0, 0, 4'h1, 1, 1, 0), 0, 1, 12'h045, 0);
      go(mk(0, 0, 4'h1, 0, 0, 0), 0, 0, 0, 0);
      go(mk(0, 0, 4'h1, 0, 1, 0), 1, 0, 0, 0);
      go(mk(0, 0, 4'h2, 0, 0, 0), 0, 1, 12'h045, 0);
      cond = 15'h0006;
      go(mk(0, 0, 4'h2, 0, 1, 0), 1, 0, 0, 0);
      cond = 15'h0002;
      go(mk(0, 1, 4'h1, 0, 0, 0), 0, 0, 0, 0);
      chk(link_register, 12'h000);
      go(mk(0, 1, 4'h1, 1, 0, 0), 0, 1, 12'h045, 0);
      chk(link_register, 12'h013);
      go(mk(2, 0, 4'hF, 0, 1, 0), 1, 1, 12'h013, 0);
      lw_en = 1'b1;
      @(negedge clk);
      lw_en = 1'b0;
      chk(link_register, 12'h0A5);
      go(mk(2, 0, 4'hF, 0, 0, 0), 0, 1, 12'h0A5, 0);
      for (int i = 0; i < 4; i++) go(mk(0, 0, 4'h1, 0, 0, ops[i]), 0, 0, 0, 4'h8 >> i);
      sw_en = 1'b1;
      @(negedge clk);
      sw_en = 1'b0;
      chk(shadow, 16'h0ABC);
      fmr = '{1'b1, 1'b1, 16'h0123};
      @(negedge clk);
      fmr = '{1'b1, 1'b1, 16'h0000};
      @(negedge clk);
      fmr = '{1'b1, 1'b0, 16'h0777};
      @(negedge clk);
      fmr = '0;
      chk(shadow, 16'h0123);
      pend = 1'b1;
      branch = mk(1, 0, 4'hF, 0, 0, 0);
      @(negedge clk);
      chk(stall, 1'b1);
      pend = 1'b0;
      go(mk(1, 0, 4'hF, 0, 0, 0), 0, 1, 12'h123, 0);
      complete_run();
   end
endmodule // bsu_branch_sequencer_unit_tb
`default_nettype wire
